//--- bxc_config_regs.v
`timescale 1ns/1ps
`include "bxc_regs.vh"

module bxc_config_regs (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Frame timing from the image pipe
  input wire frame_start,
  input wire frame_end,
  // Averaged result words from the block summer
  input wire [`BXC_AVG_W-1:0] avg_data,
  input wire avg_data_valid,
  // Settings and results to the averaging datapath and SDRAM writer
  output wire avg_active,
  output wire avg_in_frame,
  output wire tile_is_16,
  output wire [31:0] dest_base_addr,
  output wire [`BXC_AVG_W-1:0] scaled_data,
  output wire scaled_data_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg run_reg;
  reg single_pass_choice_reg;
  reg tile_dim_reg;
  reg [2:0] downscale_reg;
  reg [15:0] base_upper_reg;
  reg [10:0] base_lower_reg;
  reg in_frame_reg;
  reg pass_done_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are held separately, taken in any order

  reg aw_held_reg;
  reg [11:0] aw_addr_reg;
  reg w_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire do_write;
  wire wr_hit;
  wire [15:0] wr_val;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  // Only the two low byte lanes hold state; upper lanes are reserved
  assign wr_val = {w_strb_reg[1] ? w_data_reg[15:8] : 8'h00,
                   w_strb_reg[0] ? w_data_reg[7:0] : 8'h00};

  assign wr_hit = ({2'b00, aw_addr_reg[11:2]} <= (`BXC_OFS_STATUS >> 2));

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BXC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `BXC_RESP_OKAY : `BXC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register updates

  // A write to the policy register, or to the run register at exact address 0x000, re-arms a finished single pass
  wire rearm;
  wire pass_end;
  assign rearm = do_write && ((aw_addr_reg == `BXC_OFS_RUN_CTL) ||
                 ({2'b00, aw_addr_reg[11:2]} == (`BXC_OFS_CAPTURE_POLICY >> 2)));
  assign avg_active = run_reg && !pass_done_reg;
  assign pass_end = frame_end && in_frame_reg && single_pass_choice_reg;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_reg <= `BXC_RST_RUN;
      single_pass_choice_reg <= `BXC_RST_POLICY;
      tile_dim_reg <= `BXC_RST_TILE;
      downscale_reg <= `BXC_RST_SHIFT;
      base_upper_reg <= `BXC_RST_UPPER;
      base_lower_reg <= `BXC_RST_LOWER;
    end
    else if (do_write)
    begin
      case ({2'b00, aw_addr_reg[11:2]})
        (`BXC_OFS_RUN_CTL >> 2):
          run_reg <= wr_val[`BXC_RUN_BIT];
        (`BXC_OFS_CAPTURE_POLICY >> 2):
          single_pass_choice_reg <= wr_val[`BXC_SINGLE_PASS_BIT];
        (`BXC_OFS_TILE_DIM >> 2):
          tile_dim_reg <= wr_val[`BXC_TILE_BIT];
        (`BXC_OFS_OUTPUT_DOWNSCALE >> 2):
          downscale_reg <= wr_val[`BXC_SHIFT_MSB:0];
        (`BXC_OFS_DEST_BASE_UPPER >> 2):
          base_upper_reg <= wr_val[`BXC_UPPER_MSB:0];
        (`BXC_OFS_DEST_BASE_LOWER >> 2):
          base_lower_reg <= wr_val[`BXC_LOWER_MSB:`BXC_LOWER_LSB];
        default:
          run_reg <= run_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame tracking and single-pass completion

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_frame_reg <= 1'b0;
      pass_done_reg <= 1'b0;
    end
    else
    begin
      // A frame only counts if it starts while the unit is active
      if (frame_start && avg_active)
        in_frame_reg <= 1'b1;
      else if (frame_end || !run_reg)
        in_frame_reg <= 1'b0;
      // Completion beats a re-arm in the same cycle so the pass is not lost
      if (pass_end)
        pass_done_reg <= 1'b1;
      else if (rearm)
        pass_done_reg <= 1'b0;
    end
  end

  assign avg_in_frame = in_frame_reg;
  assign tile_is_16 = tile_dim_reg;
  assign dest_base_addr = {base_upper_reg, base_lower_reg,
                           {`BXC_ALIGN_BITS{1'b0}}};

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one-cycle registered answer

  reg [31:0] rd_word;
  reg rd_hit;

  assign s_axi_arready = !s_axi_rvalid;

  always @*
  begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    // Reserved positions are left at zero in every word
    case ({2'b00, s_axi_araddr[11:2]})
      (`BXC_OFS_RUN_CTL >> 2):
        rd_word[`BXC_RUN_BIT] = run_reg;
      (`BXC_OFS_CAPTURE_POLICY >> 2):
        rd_word[`BXC_SINGLE_PASS_BIT] = single_pass_choice_reg;
      (`BXC_OFS_TILE_DIM >> 2):
        rd_word[`BXC_TILE_BIT] = tile_dim_reg;
      (`BXC_OFS_OUTPUT_DOWNSCALE >> 2):
        rd_word[`BXC_SHIFT_MSB:0] = downscale_reg;
      (`BXC_OFS_DEST_BASE_UPPER >> 2):
        rd_word[`BXC_UPPER_MSB:0] = base_upper_reg;
      (`BXC_OFS_DEST_BASE_LOWER >> 2):
        rd_word[`BXC_LOWER_MSB:`BXC_LOWER_LSB] = base_lower_reg;
      (`BXC_OFS_STATUS >> 2):
      begin
        rd_word[`BXC_STAT_ACTIVE_BIT] = avg_active;
        rd_word[`BXC_STAT_IN_FRAME_BIT] = in_frame_reg;
        rd_word[`BXC_STAT_DONE_BIT] = pass_done_reg;
      end
      default:
        rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `BXC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `BXC_RESP_OKAY : `BXC_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output scaling of averaged words

  bxc_downshift u_downshift (
    .aclk(aclk),
    .aresetn(aresetn),
    .shift_amount(downscale_reg),
    .gate(in_frame_reg),
    .avg_in(avg_data),
    .avg_in_valid(avg_data_valid),
    .avg_out(scaled_data),
    .avg_out_valid(scaled_data_valid)
  );

endmodule // bxc_config_regs

//--- bxc_regs.vh
`ifndef BXC_REGS_VH
`define BXC_REGS_VH

// Byte offsets of the register words
`define BXC_OFS_RUN_CTL 12'h000
`define BXC_OFS_CAPTURE_POLICY 12'h004
`define BXC_OFS_TILE_DIM 12'h008
`define BXC_OFS_OUTPUT_DOWNSCALE 12'h00c
`define BXC_OFS_DEST_BASE_UPPER 12'h010
`define BXC_OFS_DEST_BASE_LOWER 12'h014
`define BXC_OFS_STATUS 12'h018

// Field positions and widths
`define BXC_RUN_BIT 0
`define BXC_SINGLE_PASS_BIT 0
`define BXC_TILE_BIT 0
`define BXC_SHIFT_MSB 2
`define BXC_UPPER_MSB 15
`define BXC_LOWER_MSB 15
`define BXC_LOWER_LSB 5
`define BXC_ALIGN_BITS 5
`define BXC_STAT_ACTIVE_BIT 0
`define BXC_STAT_IN_FRAME_BIT 1
`define BXC_STAT_DONE_BIT 2

// Reset values
`define BXC_RST_RUN 1'h0
`define BXC_RST_POLICY 1'h0
`define BXC_RST_TILE 1'h0
`define BXC_RST_SHIFT 3'h0
`define BXC_RST_UPPER 16'h0000
`define BXC_RST_LOWER 11'h000

// Bus answers
`define BXC_RESP_OKAY 2'h0
`define BXC_RESP_SLVERR 2'h2

// Width of an averaged result word
`define BXC_AVG_W 16

`endif

//--- bxc_downshift.v
`timescale 1ns/1ps
`include "bxc_regs.vh"

module bxc_downshift (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire [2:0] shift_amount,
  input wire gate,
  // Averaged result in
  input wire [`BXC_AVG_W-1:0] avg_in,
  input wire avg_in_valid,
  // Scaled result out
  output reg [`BXC_AVG_W-1:0] avg_out,
  output reg avg_out_valid
);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      avg_out <= {`BXC_AVG_W{1'b0}};
      avg_out_valid <= 1'b0;
    end
    else
    begin
      // Amounts above four are shifted as written; software keeps to 0..4
      avg_out_valid <= avg_in_valid & gate;
      if (avg_in_valid & gate)
        avg_out <= avg_in >> shift_amount;
    end
  end

endmodule // bxc_downshift

//--- bxc_config_regs_props.sv
`timescale 1ns/1ps
module bxc_config_regs_props (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Register bus
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // Frame and datapath
  input logic frame_start,
  input logic frame_end,
  input logic [15:0] avg_data,
  input logic avg_data_valid,
  input logic avg_active,
  input logic avg_in_frame,
  input logic [31:0] dest_base_addr,
  input logic [15:0] scaled_data,
  input logic scaled_data_valid
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  arready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  wresp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  base_align_a: assert property (dest_base_addr[4:0] == 5'h0)
    else $error("start address not aligned");
  scale_out_a: assert property (avg_data_valid && avg_in_frame |=>
    scaled_data_valid && scaled_data <= $past(avg_data)) else $error("scaled word wrong");
  drop_word_a: assert property (!avg_in_frame |=> !scaled_data_valid)
    else $error("word passed outside frame");
  frame_open_a: assert property ($rose(avg_in_frame) |-> $past(frame_start && avg_active))
    else $error("frame opened while idle");
  frame_close_a: assert property (avg_in_frame && frame_end && !frame_start |=> !avg_in_frame)
    else $error("frame not closed");
endmodule // bxc_config_regs_props

bind bxc_config_regs bxc_config_regs_props i_bxc_config_regs_props (.*);

//--- boxcar_config_registers_tb_top.sv
`timescale 1ns/1ps
module boxcar_config_registers_tb_top;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic frame_start = 1'h0, frame_end = 1'h0, avg_data_valid = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, d, u;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [15:0] avg_data = 16'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire avg_active, avg_in_frame, tile_is_16, scaled_data_valid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, dest_base_addr;
  wire [15:0] scaled_data;
  integer err_count = 0, check_count = 0, i, s;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [15:0] sq[$];
  logic [31:0] msk [0:5] = '{32'h1, 32'h1, 32'h1, 32'h7, 32'hffff, 32'hffe0};

  bxc_config_regs i_bxc_config_regs (.*);

  always #25 aclk = ~aclk;
  ////////////////////////////////////////
  task chk(input [33:0] a, input [33:0] b);
  begin
    check_count++;
    if (a !== b)
    begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, a, b);
    end
  end
  endtask

  task give_verdict;
  begin
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  // A wait that ran out ends the run
  task to(input integer n);
    if (n >= 50)
    begin
      err_count++;
      give_verdict;
    end
  endtask

  task wr(input [11:0] a, input [31:0] v, input [1:0] r);
    integer n;
  begin
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'h0;
    to(n);
    // Let an edge pass so a following call never re-raises bready in this step
    @(posedge aclk);
  end
  endtask

  task rd(input [11:0] a, input [33:0] e);
    integer n;
  begin
    rq.push_back(e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'h0;
    to(n);
    @(posedge aclk);
  end
  endtask

  task fr(input [1:0] se);
  begin
    {frame_start, frame_end} <= se;
    @(posedge aclk);
    {frame_start, frame_end} <= 2'h0;
    repeat (2) @(posedge aclk);
  end
  endtask

  // Only words inside a running frame are expected back
  task dv(input [15:0] v, input [2:0] sh, input e);
  begin
    if (e) sq.push_back(v >> sh);
    avg_data <= v;
    avg_data_valid <= 1'h1;
    @(posedge aclk);
    avg_data_valid <= 1'h0;
    repeat (2) @(posedge aclk);
  end
  endtask
  ////////////////////////////////////////
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, bq.pop_front());
    if (scaled_data_valid) chk(scaled_data, sq.size() ? sq.pop_front() : 34'h300000000);
  end

  initial
  begin
    d = $urandom(32'h1bbc6f5f);
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (i = 0; i < 7; i++) rd(12'(4 * i), 34'h0);
    rd(12'h020, {2'h2, 32'h0});
    wr(12'h020, 32'hffffffff, 2'h2);
    $display("reset test done");
    for (s = 0; s < 2; s++)
      for (i = 0; i < 6; i++)
      begin
        // Software keeps reserved bits at zero and the shift within 0..4
        d = (s ? $urandom : 32'hffffffff) & msk[i];
        if (i == 3) d = d % 5;
        wr(12'(4 * i), d, 2'h0);
        rd(12'(4 * i), {2'h0, d & msk[i]});
        if (i == 2) chk(tile_is_16, d[0]);
        if (i == 4) u = d;
        if (i == 5) chk(dest_base_addr, {u[15:0], d[15:5], 5'h0});
      end
    $display("field test done");
    wr(12'h004, 32'h0, 2'h0);
    wr(12'h000, 32'h1, 2'h0);
    for (s = 0; s < 5; s++)
    begin
      wr(12'h00c, s, 2'h0);
      fr(2'h2);
      chk(avg_in_frame, 1'h1);
      d = $urandom;
      dv(d[15:0], s[2:0], 1'h1);
      fr(2'h1);
      dv(d[31:16], s[2:0], 1'h0);
      chk(avg_active, 1'h1);
    end
    wr(12'h000, 32'h0, 2'h0);
    fr(2'h2);
    chk(avg_active, 1'h0);
    dv(16'h1234, 3'h0, 1'h0);
    $display("shift and enable test done");
    wr(12'h004, 32'h1, 2'h0);
    wr(12'h000, 32'h1, 2'h0);
    fr(2'h2);
    dv(16'habcd, 3'h4, 1'h1);
    fr(2'h1);
    chk(avg_active, 1'h0);
    rd(12'h018, {2'h0, 32'h4});
    fr(2'h2);
    chk(avg_in_frame, 1'h0);
    wr(12'h000, 32'h1, 2'h0);
    chk(avg_active, 1'h1);
    $display("single pass test done");
    chk(rq.size() + bq.size() + sq.size(), 0);
    give_verdict;
  end
endmodule // boxcar_config_registers_tb_top
